//--- core/tim_pkg.sv
package tim_pkg;
  // instruction byte lengths
  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;
  // execution times in system clock cycles
  localparam logic [2:0] CYC_1 = 3'h1;
  localparam logic [2:0] CYC_2 = 3'h2;
  localparam logic [2:0] CYC_3 = 3'h3;
  localparam logic [2:0] CYC_4 = 3'h4;
  localparam logic [2:0] CYC_5 = 3'h5;
  localparam logic [2:0] CYC_6 = 3'h6;
  // exact opcodes
  localparam logic [7:0] OP_NO_OPERATION = 8'h00;
  localparam logic [7:0] OP_UNUSED       = 8'hA5;
  localparam logic [7:0] OP_EXT_A_DP     = 8'hE0;
  localparam logic [7:0] OP_EXT_DP_A     = 8'hF0;
  localparam logic [7:0] OP_CODE_DP      = 8'h93;
  localparam logic [7:0] OP_CODE_PC      = 8'h83;
  localparam logic [7:0] OP_JUMP_CY      = 8'h40;
  localparam logic [7:0] OP_JUMP_NCY     = 8'h50;
  localparam logic [7:0] OP_JUMP_ZERO    = 8'h60;
  localparam logic [7:0] OP_JUMP_NZERO   = 8'h70;
  localparam logic [7:0] OP_JUMP_BIT     = 8'h20;
  localparam logic [7:0] OP_JUMP_NBIT    = 8'h30;
  localparam logic [7:0] OP_BTC_BRANCH   = 8'h10;
  localparam logic [7:0] OP_CMP_A_DIR    = 8'hB5;
  localparam logic [7:0] OP_CMP_A_IMM    = 8'hB4;
  localparam logic [7:0] OP_DEC_DIR_BR   = 8'hD5;
  localparam logic [7:0] OP_SHORT_JUMP   = 8'h80;
  localparam logic [7:0] OP_JUMP_IND     = 8'h73;
  localparam logic [7:0] OP_FULL_JUMP    = 8'h02;
  localparam logic [7:0] OP_FULL_CALL    = 8'h12;
  localparam logic [7:0] OP_DP_LOAD      = 8'h90;
  localparam logic [7:0] OP_MOV_DD       = 8'h85;
  localparam logic [7:0] OP_ROT_L        = 8'h23;
  localparam logic [7:0] OP_ROT_LC       = 8'h33;
  localparam logic [7:0] OP_ROT_R        = 8'h03;
  localparam logic [7:0] OP_ROT_RC       = 8'h13;
  localparam logic [7:0] OP_ACC_CLEAR    = 8'hE4;
  localparam logic [7:0] OP_ACC_INVERT   = 8'hF4;
  localparam logic [7:0] OP_ACC_SWAP     = 8'hC4;
  localparam logic [7:0] OP_BIT_CLEAR    = 8'hC2;
  localparam logic [7:0] OP_BIT_SET      = 8'hD2;
  localparam logic [7:0] OP_BIT_INVERT   = 8'hB2;
  localparam logic [7:0] OP_BIT_AND      = 8'h82;
  localparam logic [7:0] OP_BIT_ANDN     = 8'hB0;
  localparam logic [7:0] OP_BIT_OR       = 8'h72;
  localparam logic [7:0] OP_BIT_ORN      = 8'hA0;
  localparam logic [7:0] OP_BIT_TO_CY    = 8'hA2;
  localparam logic [7:0] OP_CY_TO_BIT    = 8'h92;
  localparam logic [7:0] OP_STACK_PUSH   = 8'hC0;
  localparam logic [7:0] OP_STACK_POP    = 8'hD0;
  // opcode families: masked compare
  localparam logic [7:0] FAM_WREG_MASK   = 8'hF8;
  localparam logic [7:0] OP_DEC_WREG_BR  = 8'hD8;
  localparam logic [7:0] OP_CMP_WREG     = 8'hB8;
  localparam logic [7:0] FAM_IND_MASK    = 8'hFE;
  localparam logic [7:0] OP_EXT_A_IND    = 8'hE2;
  localparam logic [7:0] OP_EXT_IND_A    = 8'hF2;
  localparam logic [7:0] OP_CMP_IND      = 8'hB6;
  localparam logic [7:0] OP_IND_WRITE    = 8'hF6;
  localparam logic [7:0] OP_NIBBLE_XCH   = 8'hD6;
  localparam logic [7:0] FAM_PAGE_MASK   = 8'h1F;
  localparam logic [7:0] OP_PAGE_JUMP    = 8'h01;
  localparam logic [7:0] OP_PAGE_CALL    = 8'h11;
  // addressing
  localparam logic [7:0] BIT_RAM_BASE    = 8'h20;
  localparam int         PAGE_BITS       = 11;
  localparam int         CODE_BYTES_DEF  = 8192;

  typedef enum logic [4:0] {
    CLS_OTHER, CLS_NO_OPERATION, CLS_EXT_MOVE, CLS_CODE_READ, CLS_COND_SHORT,
    CLS_COND_LONG, CLS_CMP_IND, CLS_SHORT_JUMP, CLS_JUMP_IND, CLS_PAGE, CLS_FULL,
    CLS_DP_LOAD, CLS_MOV_DD, CLS_IND_WRITE, CLS_NIBBLE_XCH, CLS_ACC_UNARY,
    CLS_BIT_OP, CLS_STACK
  } instr_class_e;

  typedef enum logic [0:0] {S_IDLE, S_EXEC} seq_state_e;

  typedef struct packed {
    logic [7:0]  opcode;
    logic [7:0]  op1;
    logic [7:0]  op2;
    logic [15:0] addr;
  } instr_s;

  typedef struct packed {
    logic [7:0]  acc;
    logic [15:0] data_pointer;
    logic [7:0]  r0;
    logic [7:0]  r1;
    logic [1:0]  bank;
    logic        taken;
  } ctx_s;

  typedef struct packed {
    instr_class_e cls;
    logic [1:0]   len;
    logic [2:0]   cyc_nt;
    logic [2:0]   cyc_t;
  } decode_s;

  typedef struct packed {
    instr_class_e cls;
    logic         recognised;
    logic [1:0]   len;
    logic [2:0]   cycles;
    logic         redirect;
    logic         is_call;
    logic [15:0]  next_addr;
    logic [15:0]  target;
    logic         target_in_code;
    logic [15:0]  mem_addr;
    logic         direct_valid;
    logic [7:0]   direct_addr;
    logic         direct_is_special;
    logic         wreg_valid;
    logic [4:0]   wreg_addr;
    logic         ind_valid;
    logic [4:0]   ind_reg_addr;
    logic [7:0]   ind_addr;
  } result_s;

  typedef struct packed {
    seq_state_e fsm;
    logic [2:0] remain;
    result_s    res;
  } seq_s;
endpackage : tim_pkg

//--- core/cpu_instruction_timing.sv
`timescale 1ns/1ps
module cpu_instruction_timing #(
  parameter int CODE_BYTES = tim_pkg::CODE_BYTES_DEF  // program memory span
) (
  // clock and reset
  input  wire logic            CLK_I,
  input  wire logic            SRST_I,
  // instruction issue
  input  wire logic            INSTR_VALID_I,
  input  wire tim_pkg::instr_s INSTR_I,
  input  wire tim_pkg::ctx_s   CTX_I,
  output logic                 INSTR_READY_O,
  // decode result and sequencing
  output tim_pkg::result_s     RESULT_O,
  output logic                 BUSY_O,
  output logic                 DONE_O
);

  // a page must fit and targets are 16 bits wide
  if (CODE_BYTES < (1 << tim_pkg::PAGE_BITS) || CODE_BYTES > 65536) begin : g_chk
    $error("CODE_BYTES out of range");
  end

  tim_pkg::seq_s    st;        // whole sequencer state
  tim_pkg::seq_s    next_st;   // its next value
  tim_pkg::decode_s dec;       // decode of the offered opcode
  tim_pkg::result_s issue;     // result formed for the offered instruction
  logic             accept;    // instruction taken this cycle
  logic             done;      // last cycle of the running instruction

  // one row of the timing table
  function automatic tim_pkg::decode_s mk(input tim_pkg::instr_class_e c,
                                          input logic [1:0] l,
                                          input logic [2:0] nt,
                                          input logic [2:0] t);
    tim_pkg::decode_s r;
    r.cls    = c;
    r.len    = l;
    r.cyc_nt = nt;
    r.cyc_t  = t;
    return r;
  endfunction : mk

  // opcode to class, length and cycle pair
  function automatic tim_pkg::decode_s decode_op(input logic [7:0] op);
    tim_pkg::decode_s d;
    d = mk(tim_pkg::CLS_OTHER, tim_pkg::LEN_1, tim_pkg::CYC_1, tim_pkg::CYC_1);
    case (op)
      // unused opcode is folded onto the idle instruction
      tim_pkg::OP_NO_OPERATION, tim_pkg::OP_UNUSED: begin
        d = mk(tim_pkg::CLS_NO_OPERATION, tim_pkg::LEN_1, tim_pkg::CYC_1, tim_pkg::CYC_1);
      end
      tim_pkg::OP_EXT_A_DP, tim_pkg::OP_EXT_DP_A: begin
        d = mk(tim_pkg::CLS_EXT_MOVE, tim_pkg::LEN_1, tim_pkg::CYC_3, tim_pkg::CYC_3);
      end
      tim_pkg::OP_CODE_DP, tim_pkg::OP_CODE_PC: begin
        d = mk(tim_pkg::CLS_CODE_READ, tim_pkg::LEN_1, tim_pkg::CYC_3, tim_pkg::CYC_3);
      end
      tim_pkg::OP_JUMP_CY, tim_pkg::OP_JUMP_NCY, tim_pkg::OP_JUMP_ZERO,
      tim_pkg::OP_JUMP_NZERO: begin
        d = mk(tim_pkg::CLS_COND_SHORT, tim_pkg::LEN_2, tim_pkg::CYC_2, tim_pkg::CYC_4);
      end
      tim_pkg::OP_JUMP_BIT, tim_pkg::OP_JUMP_NBIT, tim_pkg::OP_BTC_BRANCH,
      tim_pkg::OP_CMP_A_DIR, tim_pkg::OP_CMP_A_IMM, tim_pkg::OP_DEC_DIR_BR: begin
        d = mk(tim_pkg::CLS_COND_LONG, tim_pkg::LEN_3, tim_pkg::CYC_3, tim_pkg::CYC_5);
      end
      tim_pkg::OP_SHORT_JUMP: begin
        d = mk(tim_pkg::CLS_SHORT_JUMP, tim_pkg::LEN_2, tim_pkg::CYC_4, tim_pkg::CYC_4);
      end
      tim_pkg::OP_JUMP_IND: begin
        d = mk(tim_pkg::CLS_JUMP_IND, tim_pkg::LEN_1, tim_pkg::CYC_4, tim_pkg::CYC_4);
      end
      tim_pkg::OP_FULL_JUMP, tim_pkg::OP_FULL_CALL: begin
        d = mk(tim_pkg::CLS_FULL, tim_pkg::LEN_3, tim_pkg::CYC_5, tim_pkg::CYC_5);
      end
      tim_pkg::OP_DP_LOAD: begin
        d = mk(tim_pkg::CLS_DP_LOAD, tim_pkg::LEN_3, tim_pkg::CYC_3, tim_pkg::CYC_3);
      end
      tim_pkg::OP_MOV_DD: begin
        d = mk(tim_pkg::CLS_MOV_DD, tim_pkg::LEN_3, tim_pkg::CYC_3, tim_pkg::CYC_3);
      end
      tim_pkg::OP_ROT_L, tim_pkg::OP_ROT_LC, tim_pkg::OP_ROT_R, tim_pkg::OP_ROT_RC,
      tim_pkg::OP_ACC_CLEAR, tim_pkg::OP_ACC_INVERT, tim_pkg::OP_ACC_SWAP: begin
        d = mk(tim_pkg::CLS_ACC_UNARY, tim_pkg::LEN_1, tim_pkg::CYC_1, tim_pkg::CYC_1);
      end
      tim_pkg::OP_BIT_CLEAR, tim_pkg::OP_BIT_SET, tim_pkg::OP_BIT_INVERT,
      tim_pkg::OP_BIT_AND, tim_pkg::OP_BIT_ANDN, tim_pkg::OP_BIT_OR, tim_pkg::OP_BIT_ORN,
      tim_pkg::OP_BIT_TO_CY, tim_pkg::OP_CY_TO_BIT: begin
        d = mk(tim_pkg::CLS_BIT_OP, tim_pkg::LEN_2, tim_pkg::CYC_2, tim_pkg::CYC_2);
      end
      tim_pkg::OP_STACK_PUSH, tim_pkg::OP_STACK_POP: begin
        d = mk(tim_pkg::CLS_STACK, tim_pkg::LEN_2, tim_pkg::CYC_2, tim_pkg::CYC_2);
      end
      // families that carry a register number in the low bits or page address bits in the high three
      default: begin
        if ((op & tim_pkg::FAM_WREG_MASK) == tim_pkg::OP_DEC_WREG_BR) begin
          d = mk(tim_pkg::CLS_COND_SHORT, tim_pkg::LEN_2, tim_pkg::CYC_2, tim_pkg::CYC_4);
        end else if ((op & tim_pkg::FAM_WREG_MASK) == tim_pkg::OP_CMP_WREG) begin
          d = mk(tim_pkg::CLS_COND_LONG, tim_pkg::LEN_3, tim_pkg::CYC_3, tim_pkg::CYC_5);
        end else if ((op & tim_pkg::FAM_IND_MASK) == tim_pkg::OP_CMP_IND) begin
          d = mk(tim_pkg::CLS_CMP_IND, tim_pkg::LEN_3, tim_pkg::CYC_4, tim_pkg::CYC_6);
        end else if ((op & tim_pkg::FAM_IND_MASK) == tim_pkg::OP_EXT_A_IND ||
                     (op & tim_pkg::FAM_IND_MASK) == tim_pkg::OP_EXT_IND_A) begin
          d = mk(tim_pkg::CLS_EXT_MOVE, tim_pkg::LEN_1, tim_pkg::CYC_3, tim_pkg::CYC_3);
        end else if ((op & tim_pkg::FAM_IND_MASK) == tim_pkg::OP_IND_WRITE) begin
          d = mk(tim_pkg::CLS_IND_WRITE, tim_pkg::LEN_1, tim_pkg::CYC_2, tim_pkg::CYC_2);
        end else if ((op & tim_pkg::FAM_IND_MASK) == tim_pkg::OP_NIBBLE_XCH) begin
          d = mk(tim_pkg::CLS_NIBBLE_XCH, tim_pkg::LEN_1, tim_pkg::CYC_2, tim_pkg::CYC_2);
        end else if ((op & tim_pkg::FAM_PAGE_MASK) == tim_pkg::OP_PAGE_JUMP ||
                     (op & tim_pkg::FAM_PAGE_MASK) == tim_pkg::OP_PAGE_CALL) begin
          d = mk(tim_pkg::CLS_PAGE, tim_pkg::LEN_2, tim_pkg::CYC_4, tim_pkg::CYC_4);
        end
      end
    endcase
    return d;
  endfunction : decode_op

  // byte address holding a direct bit
  function automatic logic [7:0] bit_byte(input logic [7:0] b);
    return b[7] ? {b[7:3], 3'h0} : 8'(tim_pkg::BIT_RAM_BASE + {4'h0, b[6:3]});
  endfunction : bit_byte

  assign dec = decode_op(INSTR_I.opcode);

  // result of the offered instruction, latched on accept
  always_comb begin
    logic [7:0]  op;
    logic [7:0]  rel;
    logic [15:0] rel_tgt;
    logic        cond;
    logic        uncond;
    logic        is_bit;
    logic        ind;
    op     = INSTR_I.opcode;
    issue  = '0;
    rel    = 8'h00;
    rel_tgt = 16'h0000;
    cond   = dec.cls inside {tim_pkg::CLS_COND_SHORT, tim_pkg::CLS_COND_LONG,
                             tim_pkg::CLS_CMP_IND};
    uncond = dec.cls inside {tim_pkg::CLS_SHORT_JUMP, tim_pkg::CLS_JUMP_IND,
                             tim_pkg::CLS_PAGE, tim_pkg::CLS_FULL};
    is_bit = dec.cls == tim_pkg::CLS_BIT_OP || op == tim_pkg::OP_JUMP_BIT ||
             op == tim_pkg::OP_JUMP_NBIT || op == tim_pkg::OP_BTC_BRANCH;
    ind    = dec.cls inside {tim_pkg::CLS_CMP_IND, tim_pkg::CLS_IND_WRITE,
                             tim_pkg::CLS_NIBBLE_XCH} ||
             (dec.cls == tim_pkg::CLS_EXT_MOVE && op[1]);
    issue.cls        = dec.cls;
    issue.recognised = dec.cls != tim_pkg::CLS_OTHER;
    issue.len        = dec.len;
    issue.next_addr  = 16'(INSTR_I.addr + {14'h0, dec.len});
    // displacement is the last byte of the instruction
    rel              = (dec.len == tim_pkg::LEN_3) ? INSTR_I.op2 : INSTR_I.op1;
    rel_tgt          = 16'(issue.next_addr + {{8{rel[7]}}, rel});
    issue.redirect   = uncond || (cond && CTX_I.taken);
    // larger count only when control really leaves the fall-through path
    issue.cycles     = issue.redirect ? dec.cyc_t : dec.cyc_nt;
    issue.is_call    = op == tim_pkg::OP_FULL_CALL ||
                       (op & tim_pkg::FAM_PAGE_MASK) == tim_pkg::OP_PAGE_CALL;
    // branch destination; fall-through when not redirected
    case (dec.cls)
      tim_pkg::CLS_JUMP_IND: begin
        issue.target = 16'(CTX_I.data_pointer + {8'h00, CTX_I.acc});
      end
      tim_pkg::CLS_PAGE: issue.target = {issue.next_addr[15:tim_pkg::PAGE_BITS],
                                         op[7:5], INSTR_I.op1};
      tim_pkg::CLS_FULL: issue.target = {INSTR_I.op1, INSTR_I.op2};
      default: issue.target = issue.redirect ? rel_tgt : issue.next_addr;
    endcase
    // flag targets past the program memory, the core does not wrap them
    issue.target_in_code = 32'(issue.target) < CODE_BYTES;
    // operand address of external and code memory accesses
    case (dec.cls)
      tim_pkg::CLS_CODE_READ: begin
        issue.mem_addr = 16'({8'h00, CTX_I.acc} +
                         (op == tim_pkg::OP_CODE_DP ? CTX_I.data_pointer : issue.next_addr));
      end
      tim_pkg::CLS_EXT_MOVE: begin
        issue.mem_addr = op[1] ? {8'h00, op[0] ? CTX_I.r1 : CTX_I.r0} : CTX_I.data_pointer;
      end
      tim_pkg::CLS_DP_LOAD: issue.mem_addr = {INSTR_I.op1, INSTR_I.op2};
      default: issue.mem_addr = 16'h0000;
    endcase
    // direct operand, bit addresses fold to their byte
    issue.direct_valid = is_bit || dec.cls == tim_pkg::CLS_STACK ||
                         dec.cls == tim_pkg::CLS_MOV_DD ||
                         op == tim_pkg::OP_CMP_A_DIR || op == tim_pkg::OP_DEC_DIR_BR;
    issue.direct_addr  = is_bit ? bit_byte(INSTR_I.op1) : INSTR_I.op1;
    issue.direct_is_special = issue.direct_valid && issue.direct_addr[7];
    // working register in the active bank
    issue.wreg_valid = (op & tim_pkg::FAM_WREG_MASK) == tim_pkg::OP_DEC_WREG_BR ||
                       (op & tim_pkg::FAM_WREG_MASK) == tim_pkg::OP_CMP_WREG;
    issue.wreg_addr  = {CTX_I.bank, op[2:0]};
    // indirect pointer is register 0 or 1, chosen by opcode bit 0
    issue.ind_valid    = ind;
    issue.ind_reg_addr = {CTX_I.bank, 2'h0, op[0]};
    issue.ind_addr     = op[0] ? CTX_I.r1 : CTX_I.r0;
  end

  // handshake: a new instruction may enter on the last cycle of the old one
  assign BUSY_O        = st.fsm == tim_pkg::S_EXEC;
  assign done          = BUSY_O && st.remain == tim_pkg::CYC_1;
  assign DONE_O        = done;
  assign INSTR_READY_O = !BUSY_O || done;
  assign accept        = INSTR_VALID_I && INSTR_READY_O;
  assign RESULT_O      = st.res;

  // cycle sequencer, one count per system clock
  always_comb begin
    next_st = st;
    case (st.fsm)
      tim_pkg::S_IDLE: begin
        if (accept) begin
          next_st.fsm    = tim_pkg::S_EXEC;
          next_st.remain = issue.cycles;
          next_st.res    = issue;
        end
      end
      tim_pkg::S_EXEC: begin
        if (accept) begin
          next_st.remain = issue.cycles;
          next_st.res    = issue;
        end else if (done) begin
          next_st.fsm = tim_pkg::S_IDLE;
        end else begin
          next_st.remain = 3'(st.remain - 3'h1);
        end
      end
      default: next_st.fsm = tim_pkg::S_IDLE;
    endcase
  end

  // state register, synchronous reset
  always_ff @(posedge CLK_I) begin
    if (SRST_I) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SRST_I);

  property p_ext_time;
    accept && dec.cls == tim_pkg::CLS_EXT_MOVE |=> !DONE_O [*2] ##1 DONE_O;
  endproperty
  a_ext_time: assert property (p_ext_time) else $error("ext move timing");

  property p_code_read;
    accept && dec.cls == tim_pkg::CLS_CODE_READ |=>
      RESULT_O.len == 2'h1 ##0 !DONE_O [*2] ##1 DONE_O;
  endproperty
  a_code_read: assert property (p_code_read) else $error("code read timing");

  property p_short_taken;
    accept && dec.cls == tim_pkg::CLS_COND_SHORT && CTX_I.taken |=> !DONE_O [*3] ##1 DONE_O;
  endproperty
  a_short_taken: assert property (p_short_taken) else $error("short branch taken");

  property p_short_fall;
    accept && dec.cls == tim_pkg::CLS_COND_SHORT && !CTX_I.taken |=> !DONE_O ##1 DONE_O;
  endproperty
  a_short_fall: assert property (p_short_fall) else $error("short branch fall");

  property p_long_taken;
    accept && dec.cls == tim_pkg::CLS_COND_LONG && CTX_I.taken |=> !DONE_O [*4] ##1 DONE_O;
  endproperty
  a_long_taken: assert property (p_long_taken) else $error("long branch taken");

  property p_cmp_ind_fall;
    accept && dec.cls == tim_pkg::CLS_CMP_IND && !CTX_I.taken |=> !DONE_O [*3] ##1 DONE_O;
  endproperty
  a_cmp_ind_fall: assert property (p_cmp_ind_fall) else $error("cmp ind fall");

  property p_redirect;
    accept && dec.cls == tim_pkg::CLS_COND_LONG |=> RESULT_O.redirect == $past(CTX_I.taken);
  endproperty
  a_redirect: assert property (p_redirect) else $error("redirect mismatch");

  property p_rel_target;
    accept && dec.cls == tim_pkg::CLS_SHORT_JUMP |=>
      RESULT_O.next_addr == 16'($past(INSTR_I.addr) + 16'h0002) &&
      RESULT_O.target == 16'(RESULT_O.next_addr +
                             {{8{$past(INSTR_I.op1[7])}}, $past(INSTR_I.op1)});
  endproperty
  a_rel_target: assert property (p_rel_target) else $error("relative target");

  property p_page;
    accept && dec.cls == tim_pkg::CLS_PAGE |=>
      RESULT_O.target[15:11] == RESULT_O.next_addr[15:11] &&
      RESULT_O.target[10:0] == {$past(INSTR_I.opcode[7:5]), $past(INSTR_I.op1)};
  endproperty
  a_page: assert property (p_page) else $error("page target");

  property p_special;
    accept && dec.cls == tim_pkg::CLS_STACK |=>
      RESULT_O.direct_is_special == $past(INSTR_I.op1[7]);
  endproperty
  a_special: assert property (p_special) else $error("direct split");

  property p_ind;
    accept && dec.cls == tim_pkg::CLS_IND_WRITE |=>
      RESULT_O.ind_addr == ($past(INSTR_I.opcode[0]) ? $past(CTX_I.r1) : $past(CTX_I.r0))
      ##0 !DONE_O ##1 DONE_O;
  endproperty
  a_ind: assert property (p_ind) else $error("indirect write");

  property p_unused;
    accept && INSTR_I.opcode == tim_pkg::OP_UNUSED |=>
      RESULT_O.cls == tim_pkg::CLS_NO_OPERATION && DONE_O;
  endproperty
  a_unused: assert property (p_unused) else $error("unused opcode");

  property p_short_jump;
    accept && dec.cls == tim_pkg::CLS_SHORT_JUMP |=> !DONE_O [*3] ##1 DONE_O;
  endproperty
  a_short_jump: assert property (p_short_jump) else $error("short jump timing");

  property p_full_target;
    accept && dec.cls == tim_pkg::CLS_FULL |=>
      RESULT_O.target == {$past(INSTR_I.op1), $past(INSTR_I.op2)} && RESULT_O.len == 2'h3;
  endproperty
  a_full_target: assert property (p_full_target) else $error("full target");

  c_back_to_back: cover property (done && accept);
  c_cmp_ind_taken: cover property (accept && dec.cls == tim_pkg::CLS_CMP_IND && CTX_I.taken);
  c_unused: cover property (accept && INSTR_I.opcode == tim_pkg::OP_UNUSED);
  c_page_call: cover property (accept && dec.cls == tim_pkg::CLS_PAGE && issue.is_call);

endmodule : cpu_instruction_timing

//--- test/cpu_instruction_timing_tb.sv
`timescale 1ns/1ps
// one comparison: counts it, reports a mismatch at once
`define CHK(n, e, g) begin \
  compares++; \
  if ((g) !== (e)) begin \
    fail_count++; \
    $display("CHECK FAILED %s expected %0h seen %0h", n, e, g); \
  end \
end
module cpu_instruction_timing_tb;
  logic             clk;        // system clock
  logic             srst;       // synchronous reset
  logic             valid;      // instruction offer
  tim_pkg::instr_s  instr;      // offered instruction bytes
  tim_pkg::ctx_s    ctx;        // datapath context
  logic             ready;      // offer accepted when high
  tim_pkg::result_s res;        // registered decode
  logic             busy;       // executing
  logic             done;       // last execution cycle
  int               fail_count; // mismatches
  int               compares;   // comparisons made
  int               cycles;     // run length guard
  int               n;          // measured cycles to done

  cpu_instruction_timing cpu_instruction_timing_i (
    .CLK_I(clk), .SRST_I(srst), .INSTR_VALID_I(valid), .INSTR_I(instr), .CTX_I(ctx),
    .INSTR_READY_O(ready), .RESULT_O(res), .BUSY_O(busy), .DONE_O(done));

  // 10 MHz clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // closing report, shared by the main sequence and the guard
  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : print_verdict

  // a hang must not outlive 2000 cycles, about ten times the expected run of some two hundred
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      fail_count++;
      print_verdict();
    end
  end

  // offer one instruction, count cycles until done (idle core assumed)
  task automatic issue(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
                       input logic [15:0] a, input logic tk);
    @(negedge clk);
    valid = 1'b1;
    instr = '{op, b1, b2, a};
    ctx.taken = tk;
    @(negedge clk);
    valid = 1'b0;
    n = 1;
    while (done !== 1'b1 && n < 9) begin
      @(negedge clk);
      n++;
    end
  endtask : issue

  // byte length and cycle count of a fixed-time instruction
  task automatic oc(input logic [7:0] op, input logic [1:0] l, input logic [2:0] c);
    issue(op, 8'h00, 8'h00, 16'h0100, 1'b0);
    `CHK("len", l, res.len)
    `CHK("cycles", c, res.cycles)
    `CHK("done_delay", c, 3'(n))
  endtask : oc

  // a branch run both ways: fall-through short, taken long
  task automatic br(input logic [7:0] op, input logic [2:0] nt, input logic [2:0] t);
    issue(op, 8'h10, 8'h10, 16'h0200, 1'b0);
    `CHK("fall_delay", nt, 3'(n))
    `CHK("fall_redirect", 1'b0, res.redirect)
    issue(op, 8'h10, 8'h10, 16'h0200, 1'b1);
    `CHK("taken_delay", t, 3'(n))
    `CHK("taken_redirect", 1'b1, res.redirect)
  endtask : br

  // quiet state straight after reset
  task automatic test_reset();
    `CHK("busy", 1'b0, busy)
    `CHK("ready", 1'b1, ready)
    `CHK("result", tim_pkg::result_s'(0), res)
    $display("test_reset done");
  endtask : test_reset

  // fixed-time groups
  task automatic test_fixed();
    oc(8'hE0, 2'h1, 3'h3);
    oc(8'hF3, 2'h1, 3'h3);
    oc(8'h93, 2'h1, 3'h3);
    oc(8'h83, 2'h1, 3'h3);
    oc(8'h90, 2'h3, 3'h3);
    oc(8'h85, 2'h3, 3'h3);
    oc(8'hF6, 2'h1, 3'h2);
    oc(8'hD7, 2'h1, 3'h2);
    oc(8'h13, 2'h1, 3'h1);
    oc(8'hC4, 2'h1, 3'h1);
    oc(8'hB2, 2'h2, 3'h2);
    oc(8'hA0, 2'h2, 3'h2);
    oc(8'hC0, 2'h2, 3'h2);
    oc(8'hD0, 2'h2, 3'h2);
    oc(8'h80, 2'h2, 3'h4);
    oc(8'h73, 2'h1, 3'h4);
    oc(8'hA5, 2'h1, 3'h1);
    `CHK("unused_class", tim_pkg::CLS_NO_OPERATION, res.cls)
    `CHK("unused_known", 1'b1, res.recognised)
    $display("test_fixed done");
  endtask : test_fixed

  // paired counts of conditional branches
  task automatic test_branch();
    br(8'h50, 3'h2, 3'h4);
    br(8'hDF, 3'h2, 3'h4);
    br(8'h10, 3'h3, 3'h5);
    br(8'hB4, 3'h3, 3'h5);
    br(8'hD5, 3'h3, 3'h5);
    br(8'hB7, 3'h4, 3'h6);
    $display("test_branch done");
  endtask : test_branch

  // branch targets and operand selection
  task automatic test_address();
    issue(8'h80, 8'hFE, 8'h00, 16'h1000, 1'b0);
    `CHK("rel_back", 16'h1000, res.target)
    issue(8'h20, 8'h00, 8'h7F, 16'h1000, 1'b1);
    `CHK("rel_fwd", 16'h1082, res.target)
    issue(8'hE1, 8'h34, 8'h00, 16'h17FE, 1'b0);
    `CHK("page", 16'h1F34, res.target)
    issue(8'h12, 8'h1F, 8'hFF, 16'h0000, 1'b0);
    `CHK("full", 16'h1FFF, res.target)
    `CHK("in_code", 1'b1, res.target_in_code)
    issue(8'h85, 8'h7F, 8'h00, 16'h0000, 1'b0);
    `CHK("ram_side", 1'b0, res.direct_is_special)
    `CHK("direct_valid", 1'b1, res.direct_valid)
    issue(8'h85, 8'h80, 8'h00, 16'h0000, 1'b0);
    `CHK("special_side", 1'b1, res.direct_is_special)
    issue(8'hBB, 8'h00, 8'h10, 16'h0000, 1'b0);
    `CHK("wreg", 5'h13, res.wreg_addr)
    `CHK("wreg_valid", 1'b1, res.wreg_valid)
    issue(8'hF7, 8'h00, 8'h00, 16'h0000, 1'b0);
    `CHK("ind_r1", 8'h55, res.ind_addr)
    issue(8'hF6, 8'h00, 8'h00, 16'h0000, 1'b0);
    `CHK("ind_r0", 8'h40, res.ind_addr)
    $display("test_address done");
  endtask : test_address

  // operand addresses, bit folding and the program memory span
  task automatic test_fields();
    ctx.acc = 8'h10;
    ctx.data_pointer = 16'h1234;
    issue(8'h93, 8'h00, 8'h00, 16'h0100, 1'b0);
    `CHK("code_dp", 16'h1244, res.mem_addr)
    issue(8'h83, 8'h00, 8'h00, 16'h0100, 1'b0);
    `CHK("code_pc", 16'h0111, res.mem_addr)
    issue(8'hE3, 8'h00, 8'h00, 16'h0100, 1'b0);
    `CHK("ext_ind", 16'h0055, res.mem_addr)
    `CHK("ind_reg", 5'h11, res.ind_reg_addr)
    `CHK("ind_valid", 1'b1, res.ind_valid)
    issue(8'hE0, 8'h00, 8'h00, 16'h0100, 1'b0);
    `CHK("ext_dp", 16'h1234, res.mem_addr)
    issue(8'h73, 8'h00, 8'h00, 16'h0100, 1'b0);
    `CHK("jump_ind", 16'h1244, res.target)
    issue(8'hD2, 8'h0B, 8'h00, 16'h0100, 1'b0);
    `CHK("bit_ram", 8'h21, res.direct_addr)
    issue(8'hD2, 8'hE7, 8'h00, 16'h0100, 1'b0);
    `CHK("bit_special", 8'hE0, res.direct_addr)
    `CHK("bit_special_side", 1'b1, res.direct_is_special)
    issue(8'h02, 8'h20, 8'h00, 16'h0100, 1'b0);
    `CHK("past_code", 1'b0, res.target_in_code)
    $display("test_fields done");
  endtask : test_fields

  // refusal while busy, issue on the last cycle, reset in mid-run
  task automatic test_handshake();
    @(negedge clk);
    valid = 1'b1;
    instr = '{8'h31, 8'h00, 8'h00, 16'h0000};
    @(negedge clk);
    `CHK("refuse", 1'b0, ready)
    instr.opcode = 8'hE4;
    repeat (2) @(negedge clk);
    `CHK("not_yet", 1'b0, done)
    @(negedge clk);
    `CHK("page_done", 1'b1, done)
    `CHK("page_call", 1'b1, res.is_call)
    @(negedge clk);
    valid = 1'b0;
    `CHK("next_class", tim_pkg::CLS_ACC_UNARY, res.cls)
    `CHK("next_done", 1'b1, done)
    @(negedge clk);
    `CHK("idle", 1'b0, busy)
    valid = 1'b1;
    instr.opcode = 8'h90;
    @(negedge clk);
    `CHK("run_busy", 1'b1, busy)
    valid = 1'b0;
    srst = 1'b1;
    @(negedge clk);
    `CHK("reset_busy", 1'b0, busy)
    `CHK("reset_result", tim_pkg::result_s'(0), res)
    srst = 1'b0;
    @(negedge clk);
    `CHK("reset_ready", 1'b1, ready)
    $display("test_handshake done");
  endtask : test_handshake

  // main sequence
  initial begin
    fail_count = 0;
    compares = 0;
    cycles = 0;
    srst = 1'b1;
    valid = 1'b0;
    instr = '0;
    ctx = '{8'h00, 16'h0000, 8'h40, 8'h55, 2'h2, 1'b0}; // only defined fields driven
    repeat (3) @(negedge clk);
    srst = 1'b0;
    test_reset();
    test_fixed();
    test_branch();
    test_address();
    test_fields();
    test_handshake();
    print_verdict();
  end
endmodule : cpu_instruction_timing_tb
